// ===== lom_defines.vh
// Purpose: constants for the literal/move execute block
// Assumes: 14-bit instruction words, 8-bit data
// Notes:   opcode patterns and field positions
`ifndef LOM_DEFINES_VH
`define LOM_DEFINES_VH
`define LOM_INSN_W        14
`define LOM_DATA_W        8
`define LOM_IDX_W         7
`define LOM_OR_LIT_TOP    6'h38
`define LOM_LOAD_LIT_TOP  4'hC
`define LOM_COPY_REG_TOP  6'h08
`define LOM_TARGET_BIT    7
`define LOM_ACC_RST       8'h00
`define LOM_NULL_RST      1'h0
`define LOM_OP_HI         13
`define LOM_OR_LIT_LO     8
`define LOM_LOAD_LIT_LO   10
`define LOM_COPY_REG_LO   8
`define LOM_WREN_RST      1'h0
`define LOM_IDX_RST       7'h00
`define LOM_WDATA_RST     8'h00
`endif

// ===== lom_exec.v
// Purpose: decode and execute or-literal, load-literal and copy-register
// Assumes: word valid for one clk cycle per instruction cycle; async file read
// Notes:   other opcodes hold acc, null flag and write index/data; file_wr_en clears
`timescale 1ns/100ps
`include "lom_defines.vh"

module lom_exec #(
  parameter INSN_W = `LOM_INSN_W,
  parameter DATA_W = `LOM_DATA_W,
  parameter IDX_W  = `LOM_IDX_W
) (
  input  wire              clk,
  input  wire              nrst,
  input  wire              ce,
  input  wire              insn_valid,
  input  wire [INSN_W-1:0] insn_word,
  input  wire [DATA_W-1:0] file_rd_data,
  output wire [IDX_W-1:0]  file_rd_idx,
  output wire              file_wr_en,
  output wire [IDX_W-1:0]  file_wr_idx,
  output wire [DATA_W-1:0] file_wr_data,
  output wire [DATA_W-1:0] acc,
  output wire              result_null_flag
);

  // ----------------------------------------
  // instruction classes
  // ----------------------------------------
  localparam [1:0] CLS_NONE = 2'h0;
  localparam [1:0] CLS_OR   = 2'h1;
  localparam [1:0] CLS_LOAD = 2'h2;
  localparam [1:0] CLS_COPY = 2'h3;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg  [DATA_W-1:0]                     acc_reg;
  reg  [DATA_W-1:0]                     acc_next;
  reg                                   null_reg;
  reg                                   null_next;
  reg                                   wr_en_reg;
  reg                                   wr_en_next;
  reg  [IDX_W-1:0]                      wr_idx_reg;
  reg  [IDX_W-1:0]                      wr_idx_next;
  reg  [DATA_W-1:0]                     wr_data_reg;
  reg  [DATA_W-1:0]                     wr_data_next;
  reg  [1:0]                            insn_class;
  wire                                  exec_take;
  wire [`LOM_OP_HI-`LOM_OR_LIT_LO:0]    or_field;
  wire [`LOM_OP_HI-`LOM_LOAD_LIT_LO:0]  load_field;
  wire [`LOM_OP_HI-`LOM_COPY_REG_LO:0]  copy_field;
  wire                                  or_hit;
  wire                                  load_hit;
  wire                                  copy_hit;
  wire [DATA_W-1:0]                     literal_byte;
  wire                                  result_target_bit;
  wire [DATA_W-1:0]                     or_result;
  wire                                  or_is_zero;
  wire                                  move_is_zero;

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  assign exec_take         = ce && insn_valid;
  assign or_field          = insn_word[`LOM_OP_HI:`LOM_OR_LIT_LO];
  assign load_field        = insn_word[`LOM_OP_HI:`LOM_LOAD_LIT_LO];
  assign copy_field        = insn_word[`LOM_OP_HI:`LOM_COPY_REG_LO];
  assign or_hit            = (or_field == `LOM_OR_LIT_TOP);
  assign load_hit          = (load_field == `LOM_LOAD_LIT_TOP);
  assign copy_hit          = (copy_field == `LOM_COPY_REG_TOP);
  assign literal_byte      = insn_word[DATA_W-1:0];
  assign result_target_bit = insn_word[`LOM_TARGET_BIT];
  assign file_rd_idx       = insn_word[IDX_W-1:0];

  // ----------------------------------------
  // instruction class
  // ----------------------------------------
  always @* begin
    insn_class = CLS_NONE;
    if (exec_take) begin
      if (or_hit) begin
        insn_class = CLS_OR;
      end else if (load_hit) begin
        insn_class = CLS_LOAD;
      end else if (copy_hit) begin
        insn_class = CLS_COPY;
      end
    end
  end

  // ----------------------------------------
  // results
  // ----------------------------------------
  assign or_result    = acc_reg | literal_byte;
  assign or_is_zero   = (or_result == {DATA_W{1'h0}});
  assign move_is_zero = (file_rd_data == {DATA_W{1'h0}});

  // ----------------------------------------
  // accumulator next value
  // ----------------------------------------
  always @* begin
    acc_next = acc_reg;
    case (insn_class)
      CLS_OR: begin
        acc_next = or_result;
      end
      CLS_LOAD: begin
        acc_next = literal_byte;
      end
      CLS_COPY: begin
        if (!result_target_bit) begin
          acc_next = file_rd_data;
        end
      end
      default: begin
        acc_next = acc_reg;
      end
    endcase
  end

  // ----------------------------------------
  // null flag next value
  // ----------------------------------------
  always @* begin
    null_next = null_reg;
    case (insn_class)
      CLS_OR: begin
        null_next = or_is_zero;
      end
      CLS_LOAD: begin
        null_next = null_reg;
      end
      CLS_COPY: begin
        null_next = move_is_zero;
      end
      default: begin
        null_next = null_reg;
      end
    endcase
  end

  // ----------------------------------------
  // write-back next values
  // ----------------------------------------
  always @* begin
    wr_en_next   = 1'h0;
    wr_idx_next  = wr_idx_reg;
    wr_data_next = wr_data_reg;
    if ((insn_class == CLS_COPY) && result_target_bit) begin
      wr_en_next   = 1'h1;
      wr_idx_next  = file_rd_idx;
      wr_data_next = file_rd_data;
    end
  end

  // ----------------------------------------
  // accumulator register
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      acc_reg <= `LOM_ACC_RST;
    end else if (ce) begin
      acc_reg <= acc_next;
    end
  end

  // ----------------------------------------
  // null flag register
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      null_reg <= `LOM_NULL_RST;
    end else if (ce) begin
      null_reg <= null_next;
    end
  end

  // ----------------------------------------
  // write-back pulse, dropped while ce low
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      wr_en_reg <= `LOM_WREN_RST;
    end else begin
      wr_en_reg <= wr_en_next;
    end
  end

  // ----------------------------------------
  // write-back index register
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      wr_idx_reg <= `LOM_IDX_RST;
    end else if (ce) begin
      wr_idx_reg <= wr_idx_next;
    end
  end

  // ----------------------------------------
  // write-back data register
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      wr_data_reg <= `LOM_WDATA_RST;
    end else if (ce) begin
      wr_data_reg <= wr_data_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign acc              = acc_reg;
  assign result_null_flag = null_reg;
  assign file_wr_en       = wr_en_reg;
  assign file_wr_idx      = wr_idx_reg;
  assign file_wr_data     = wr_data_reg;

endmodule

// ===== lom_exec_assertions.sv
// Purpose: port checker for the literal/move execute block
// Assumes: one clk, synchronous active-low reset
// Notes:   bound from tb_top
`timescale 1ns/100ps
module lom_exec_assertions(input wire clk,nrst,ce,insn_valid,input wire [13:0] insn_word,
  input wire [7:0] file_rd_data,input wire [6:0] file_rd_idx,input wire file_wr_en,
  input wire [6:0] file_wr_idx,input wire [7:0] file_wr_data,acc,input wire result_null_flag);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire g=ce&insn_valid;
  wire [5:0] t=insn_word[13:8];
  a_or_value: assert property(g&&t==6'h38 |=> acc==($past(acc)|$past(insn_word[7:0])))
    else $error("or value");
  a_or_flag: assert property(g&&t==6'h38 |=> result_null_flag==(acc==0)&&!file_wr_en)
    else $error("or flag");
  a_load_lit: assert property(g&&t[5:2]==4'hC |=> acc==$past(insn_word[7:0])&&
    $stable(result_null_flag)) else $error("load");
  a_copy_acc: assert property(g&&t==6'h08&&!insn_word[7] |=> acc==$past(file_rd_data))
    else $error("copy acc");
  a_copy_back: assert property(g&&t==6'h08&&insn_word[7] |=> file_wr_en&&$stable(acc)&&
    file_wr_idx==$past(insn_word[6:0])&&file_wr_data==$past(file_rd_data)) else $error("wb");
  a_copy_flag: assert property(g&&t==6'h08 |=> result_null_flag==($past(file_rd_data)==0))
    else $error("copy flag");
  a_rd_index: assert property(file_rd_idx==insn_word[6:0]) else $error("index");
  a_idle_hold: assert property(!g |=> $stable(acc)&&!file_wr_en) else $error("idle");
endmodule

// ===== lom_regs.sv
// Purpose: file register model at the far side of the block
// Assumes: combinational read, write on the rising edge
// Notes:   cell i holds i at start
`timescale 1ns/100ps
module lom_regs(input wire clk,we,input wire [6:0] widx,ridx,input wire [7:0] wdata,
  output wire [7:0] rdata);
  reg [7:0] m [0:127];
  integer i;
  initial for (i=0;i<128;i=i+1) m[i]=i[7:0];
  assign rdata=m[ridx];
  always @(posedge clk) if (we) m[widx]<=wdata;
endmodule

// ===== tb_top.sv
// Purpose: testbench for the literal/move execute block
// Assumes: 100 MHz clk; file model cell i holds i at start
// Notes:   directed scenarios, inputs driven 1 ns after the rising edge
`timescale 1ns/100ps
module tb_top;
  reg        clk = 1'b0;
  reg        nrst = 1'b0;
  reg        ce = 1'b1;
  reg        v = 1'b0;
  reg [13:0] w = 14'h0000;
  wire [7:0] rd;
  wire [7:0] wd;
  wire [7:0] acc;
  wire [6:0] ri;
  wire [6:0] wi;
  wire       we;
  wire       z;
  integer    num_errors = 0;
  integer    checks = 0;
  lom_exec i_lom_exec(.clk(clk), .nrst(nrst), .ce(ce), .insn_valid(v), .insn_word(w),
    .file_rd_data(rd), .file_rd_idx(ri), .file_wr_en(we), .file_wr_idx(wi),
    .file_wr_data(wd), .acc(acc), .result_null_flag(z));
  lom_regs i_lom_regs(.clk(clk), .we(we), .widx(wi), .ridx(ri), .wdata(wd), .rdata(rd));
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(input [15:0] s, input [15:0] e); begin
    checks = checks + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  end
  endtask
  // valid stays high between back-to-back words
  task issue(input [13:0] i); begin
    w = i;
    v = 1'b1;
    @(posedge clk);
    #1;
  end
  endtask
  task idle; begin
    v = 1'b0;
    @(posedge clk);
    #1;
  end
  endtask
  task complete_run; begin
    $display("checks %0d mismatches %0d", checks, num_errors);
    if ((num_errors == 0) && (checks > 0)) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  end
  endtask
  task t_lit; begin
    issue(14'h309A);
    chk({z,acc}, 16'h009A);
    issue(14'h3835);
    chk({z,acc}, 16'h00BF);
    chk(we, 16'h0000);
    issue(14'h3000);
    chk({z,acc}, 16'h0000);
    issue(14'h3800);
    chk({z,acc}, 16'h0100);
    issue(14'h335A);
    chk({z,acc}, 16'h015A);
    issue(14'h3801);
    chk({z,acc}, 16'h005B);
    idle;
    $display("literal done");
  end
  endtask
  task t_copy; begin
    issue(14'h087F);
    chk({z,acc}, 16'h007F);
    chk(ri, 16'h007F);
    issue(14'h0880);
    chk({we,acc}, 16'h017F);
    chk({z,wi}, 16'h0080);
    chk(wd, 16'h0000);
    issue(14'h0885);
    chk({z,we,wi}, 16'h0085);
    chk({wd,acc}, 16'h057F);
    issue(14'h0805);
    chk({we,z,acc}, 16'h0005);
    idle;
    $display("copy done");
  end
  endtask
  task t_hold; begin
    ce = 1'b0;
    issue(14'h3000);
    chk({z,acc}, 16'h0005);
    issue(14'h0880);
    chk({we,z,acc}, 16'h0005);
    idle;
    ce = 1'b1;
    w = 14'h3800;
    @(posedge clk);
    #1;
    chk({we,z,acc}, 16'h0005);
    $display("hold done");
  end
  endtask
  task t_reset; begin
    issue(14'h0880);
    nrst = 1'b0;
    v = 1'b0;
    @(posedge clk);
    #1;
    nrst = 1'b1;
    chk({we,z,acc}, 16'h0000);
    issue(14'h3800);
    chk({z,acc}, 16'h0100);
    idle;
    $display("reset done");
  end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_lit;
    t_copy;
    t_hold;
    t_reset;
    complete_run;
  end
  initial begin
    #2000;
    num_errors = num_errors + 1;
    complete_run;
  end
endmodule
bind lom_exec lom_exec_assertions i_chk(.clk(clk), .nrst(nrst), .ce(ce),
  .insn_valid(insn_valid), .insn_word(insn_word), .file_rd_data(file_rd_data),
  .file_rd_idx(file_rd_idx), .file_wr_en(file_wr_en), .file_wr_idx(file_wr_idx),
  .file_wr_data(file_wr_data), .acc(acc), .result_null_flag(result_null_flag));
